// ---- hdl/acr_defines.svh ----
// register offsets, field masks, reset values and framing counts
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

`define ACR_ADDR_GLOBAL    8'h00
`define ACR_ADDR_SWING     8'h01
`define ACR_ADDR_PERF_ONE  8'h03
`define ACR_ADDR_GAIN_PAT  8'h25
`define ACR_ADDR_DRIVE     8'h26
`define ACR_ADDR_FORMAT    8'h3d
`define ACR_ADDR_UPAT_HI   8'h3f
`define ACR_ADDR_UPAT_LO   8'h40
`define ACR_ADDR_IFACE     8'h41
`define ACR_ADDR_SWING_EN  8'h43
`define ACR_ADDR_PERF_TWO  8'h4a

`define ACR_NUM_REGS       11

`define ACR_MASK_GLOBAL    8'h01
`define ACR_MASK_SWING     8'hfc
`define ACR_MASK_PERF_ONE  8'h03
`define ACR_MASK_GAIN_PAT  8'hf7
`define ACR_MASK_DRIVE     8'h03
`define ACR_MASK_FORMAT    8'he0
`define ACR_MASK_UPAT_HI   8'h3f
`define ACR_MASK_UPAT_LO   8'hff
`define ACR_MASK_IFACE     8'hff
`define ACR_MASK_SWING_EN  8'h03
`define ACR_MASK_PERF_TWO  8'h01

`define ACR_RST_GAIN_PAT   8'h50
`define ACR_RST_OTHER      8'h00

`define ACR_BIT_SOFT_RESET 1
`define ACR_BIT_READBACK   0

`define ACR_FRAME_BITS     5'd16
`define ACR_ADDR_BITS      5'd8

`define ACR_PAT_NORMAL     3'h0
`define ACR_PAT_ZEROS      3'h1
`define ACR_PAT_ONES       3'h2
`define ACR_PAT_TOGGLE     3'h3
`define ACR_PAT_RAMP       3'h4
`define ACR_PAT_USER       3'h5

`define ACR_TOGGLE_A       14'h1555
`define ACR_TOGGLE_B       14'h2aaa
`define ACR_MASK_WIDE      14'h3fff
`define ACR_MASK_NARROW    14'h0fff
`define ACR_GAIN_ZERO_DB   4'h5
`define ACR_SWING_ON       2'h3
`define ACR_FMT_TWOS       2'h2
`define ACR_FMT_OFFSET     2'h3
`define ACR_IF_LVDS        2'h1
`define ACR_IF_CMOS        2'h3

`endif

// ---- hdl/acr_pkg.sv ----
// types shared by the converter configuration bank
package acr_pkg;

    typedef enum logic [0:0] {
        ACR_SP_IDLE,
        ACR_SP_SHIFT
    } acr_sp_e;

    typedef struct packed {
        logic [5:0] swing_code;
        logic       clock_driver_strength;
        logic       data_driver_strength;
        logic [1:0] perf_boost_one;
        logic       perf_boost_two;
        logic [3:0] gain_code;
        logic [3:0] gain_half_db;
        logic       twos_complement;
        logic       offset_cancel_enable;
        logic       lvds_select;
        logic [1:0] parallel_clock_drive;
        logic       clock_rise_adjust_enable;
    } acr_cfg_s;

endpackage : acr_pkg

// ---- hdl/acr_bank.sv ----
// configuration register bank with serial write/readback and pattern mux
// How it works
// - writing the reset bit restores defaults; the bit never stays set
// - readback low shows over-range on the shared pin, high shifts data
// - six-bit swing code in bits 7..2 selects the output drive level
// - swing code is applied only while the override field is enabled
// - both boost modes can only be set by serial register writes
// - four-bit gain in 0.5 dB steps, 0101 is 0 dB, 0000..0100 unused
// - pattern 000 normal data, 001 all zeros, 010 all ones
// - pattern 011 alternates 0101 and 1010 words every sample
// - pattern 100 ramps; wide every clock, narrow every fourth clock
// - pattern 101 outputs the user pattern; 110 and 111 unused
// - wide variant uses user bits 13..0, narrow uses bits 13..2
// - drive bit 1 is clock buffer strength, bit 0 data buffer strength
// - format 00 follows the format pin, 10 twos complement, 11 binary
// - format register bit 5 enables the offset cancel loop
// - interface 00/10 follow the pin, 01 forces LVDS, 11 forces CMOS
// - two-bit parallel clock drive code, 00 strongest to 11 weakest
// - interface bit 3 enables rising-edge position control
// - in readback only address zero accepts writes
`timescale 1ns/1ps
`include "acr_defines.svh"

module acr_bank #(
    parameter bit WIDE_VARIANT = 1'b1
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    // serial configuration pins
    input  wire logic             ser_enable_n_in,
    input  wire logic             ser_clock_in,
    input  wire logic             ser_data_in,
    // converter side
    input  wire logic             overrange_flag_in,
    input  wire logic [13:0]      conv_data_in,
    input  wire logic             format_select_pin_in,
    // outputs
    output logic                  overrange_serial_out_pin_out,
    output logic [13:0]           sample_data_out,
    output acr_pkg::acr_cfg_s     cfg_out
);
    import acr_pkg::*;

    // pin synchronisers: first stage read only by second
    logic       fmt_meta_reg, fmt_sync_reg;
    logic       sclk_meta_reg, sclk_sync_reg, sen_n_meta_reg, sen_n_sync_reg;
    logic       sdat_meta_reg, sdat_sync_reg;
    logic       sclk_old_reg;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sclk_meta_reg  <= 1'b0;
            sclk_sync_reg  <= 1'b0;
            sclk_old_reg   <= 1'b0;
            sen_n_meta_reg <= 1'b1;
            sen_n_sync_reg <= 1'b1;
            sdat_meta_reg  <= 1'b0;
            sdat_sync_reg  <= 1'b0;
            fmt_meta_reg   <= 1'b0;
            fmt_sync_reg   <= 1'b0;
        end else begin
            sclk_meta_reg  <= ser_clock_in;
            sclk_sync_reg  <= sclk_meta_reg;
            sclk_old_reg   <= sclk_sync_reg;
            sen_n_meta_reg <= ser_enable_n_in;
            sen_n_sync_reg <= sen_n_meta_reg;
            sdat_meta_reg  <= ser_data_in;
            sdat_sync_reg  <= sdat_meta_reg;
            fmt_meta_reg   <= format_select_pin_in;
            fmt_sync_reg   <= fmt_meta_reg;
        end
    end

    logic sclk_rise;
    assign sclk_rise = sclk_sync_reg & ~sclk_old_reg & ~sen_n_sync_reg;

    // register storage, one slot per mapped address
    localparam logic [7:0] ADDR_TAB [`ACR_NUM_REGS] = '{
        `ACR_ADDR_GLOBAL, `ACR_ADDR_SWING, `ACR_ADDR_PERF_ONE,
        `ACR_ADDR_GAIN_PAT, `ACR_ADDR_DRIVE, `ACR_ADDR_FORMAT,
        `ACR_ADDR_UPAT_HI, `ACR_ADDR_UPAT_LO, `ACR_ADDR_IFACE,
        `ACR_ADDR_SWING_EN, `ACR_ADDR_PERF_TWO};
    localparam logic [7:0] MASK_TAB [`ACR_NUM_REGS] = '{
        `ACR_MASK_GLOBAL, `ACR_MASK_SWING, `ACR_MASK_PERF_ONE,
        `ACR_MASK_GAIN_PAT, `ACR_MASK_DRIVE, `ACR_MASK_FORMAT,
        `ACR_MASK_UPAT_HI, `ACR_MASK_UPAT_LO, `ACR_MASK_IFACE,
        `ACR_MASK_SWING_EN, `ACR_MASK_PERF_TWO};
    localparam logic [7:0] RST_TAB [`ACR_NUM_REGS] = '{
        `ACR_RST_OTHER, `ACR_RST_OTHER, `ACR_RST_OTHER,
        `ACR_RST_GAIN_PAT, `ACR_RST_OTHER, `ACR_RST_OTHER,
        `ACR_RST_OTHER, `ACR_RST_OTHER, `ACR_RST_OTHER,
        `ACR_RST_OTHER, `ACR_RST_OTHER};

    logic [7:0] regs_reg  [`ACR_NUM_REGS];
    logic [7:0] regs_next [`ACR_NUM_REGS];

    // serial frame state
    acr_sp_e    sp_state_reg, sp_state_next;
    logic [4:0] bit_cnt_reg, bit_cnt_next;
    logic [15:0] frame_reg, frame_next;
    logic [7:0] rd_shift_reg, rd_shift_next;
    logic       wr_commit;
    logic [15:0] frame_full;
    logic [7:0] rd_value;
    logic       readback_on;

    assign readback_on = regs_reg[0][`ACR_BIT_READBACK];
    assign frame_full  = {frame_reg[14:0], sdat_sync_reg};

    always_comb begin
        rd_value = 8'h00;
        for (int i = 1; i < `ACR_NUM_REGS; i++) begin
            if (frame_full[7:0] == ADDR_TAB[i]) begin
                rd_value = regs_reg[i];
            end
        end
    end

    always_comb begin
        sp_state_next = sp_state_reg;
        bit_cnt_next  = bit_cnt_reg;
        frame_next    = frame_reg;
        rd_shift_next = rd_shift_reg;
        wr_commit     = 1'b0;
        case (sp_state_reg)
            ACR_SP_IDLE: begin
                bit_cnt_next = 5'd0;
                if (!sen_n_sync_reg) begin
                    sp_state_next = ACR_SP_SHIFT;
                end
            end
            ACR_SP_SHIFT: begin
                if (sen_n_sync_reg) begin
                    sp_state_next = ACR_SP_IDLE;
                end else if (sclk_rise) begin
                    frame_next   = frame_full;
                    bit_cnt_next = bit_cnt_reg + 5'd1;
                    if (bit_cnt_reg + 5'd1 == `ACR_ADDR_BITS) begin
                        rd_shift_next = rd_value;
                    end else begin
                        rd_shift_next = {rd_shift_reg[6:0], 1'b0};
                    end
                    if (bit_cnt_reg + 5'd1 == `ACR_FRAME_BITS) begin
                        wr_commit     = 1'b1;
                        sp_state_next = ACR_SP_IDLE;
                    end
                end
            end
            default: sp_state_next = ACR_SP_IDLE;
        endcase
    end

    logic [7:0] wr_addr, wr_data;
    assign wr_addr = frame_full[15:8];
    assign wr_data = frame_full[7:0];

    always_comb begin
        for (int i = 0; i < `ACR_NUM_REGS; i++) begin
            regs_next[i] = regs_reg[i];
        end
        if (wr_commit) begin
            if (wr_addr == `ACR_ADDR_GLOBAL &&
                wr_data[`ACR_BIT_SOFT_RESET]) begin
                // reset bit is never stored, so it reads back zero
                for (int i = 0; i < `ACR_NUM_REGS; i++) begin
                    regs_next[i] = RST_TAB[i];
                end
            end else begin
                for (int i = 0; i < `ACR_NUM_REGS; i++) begin
                    // boost fields reach only through this path
                    if (wr_addr == ADDR_TAB[i] &&
                        (!readback_on || i == 0)) begin
                        regs_next[i] = wr_data & MASK_TAB[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sp_state_reg <= ACR_SP_IDLE;
            bit_cnt_reg  <= 5'd0;
            frame_reg    <= 16'h0000;
            rd_shift_reg <= 8'h00;
            for (int i = 0; i < `ACR_NUM_REGS; i++) begin
                regs_reg[i] <= RST_TAB[i];
            end
        end else begin
            sp_state_reg <= sp_state_next;
            bit_cnt_reg  <= bit_cnt_next;
            frame_reg    <= frame_next;
            rd_shift_reg <= rd_shift_next;
            for (int i = 0; i < `ACR_NUM_REGS; i++) begin
                regs_reg[i] <= regs_next[i];
            end
        end
    end

    // shared pin: over-range or serial readback
    logic pin_next, pin_reg;
    always_comb begin
        pin_next = readback_on ? rd_shift_reg[7]
                               : overrange_flag_in;
    end

    // decoded configuration
    acr_cfg_s cfg_next, cfg_reg;
    logic [1:0] fmt_code, if_code;
    assign fmt_code = regs_reg[5][7:6];
    assign if_code  = regs_reg[8][7:6];

    always_comb begin
        cfg_next = '0;
        if (regs_reg[9][1:0] == `ACR_SWING_ON) begin
            cfg_next.swing_code = regs_reg[1][7:2];
        end
        cfg_next.clock_driver_strength = regs_reg[4][1];
        cfg_next.data_driver_strength  = regs_reg[4][0];
        cfg_next.perf_boost_one = regs_reg[2][1:0];
        cfg_next.perf_boost_two = regs_reg[10][0];
        cfg_next.gain_code = regs_reg[3][7:4];
        // unused low codes clamp to 0 dB rather than wrap
        if (regs_reg[3][7:4] > `ACR_GAIN_ZERO_DB) begin
            cfg_next.gain_half_db = regs_reg[3][7:4] - `ACR_GAIN_ZERO_DB;
        end
        case (fmt_code)
            `ACR_FMT_TWOS:   cfg_next.twos_complement = 1'b1;
            `ACR_FMT_OFFSET: cfg_next.twos_complement = 1'b0;
            default:         cfg_next.twos_complement = fmt_sync_reg;
        endcase
        cfg_next.offset_cancel_enable = regs_reg[5][5];
        case (if_code)
            `ACR_IF_LVDS: cfg_next.lvds_select = 1'b1;
            `ACR_IF_CMOS: cfg_next.lvds_select = 1'b0;
            default:      cfg_next.lvds_select = fmt_sync_reg;
        endcase
        cfg_next.parallel_clock_drive = regs_reg[8][5:4];
        cfg_next.clock_rise_adjust_enable = regs_reg[8][3];
    end

    // output data source
    localparam logic [13:0] WMASK =
        WIDE_VARIANT ? `ACR_MASK_WIDE : `ACR_MASK_NARROW;
    logic [2:0]  pat_sel;
    logic [13:0] user_pat, data_next, data_reg, ramp_reg, ramp_next;
    logic [13:0] norm_data;
    logic        tog_reg, tog_next;
    logic [1:0]  div_reg, div_next;

    assign pat_sel  = regs_reg[3][2:0];
    assign user_pat = {regs_reg[6][5:0], regs_reg[7]};

    always_comb begin
        tog_next  = ~tog_reg;
        div_next  = div_reg + 2'd1;
        ramp_next = ramp_reg;
        if (pat_sel != `ACR_PAT_RAMP) begin
            ramp_next = 14'h0000;
            div_next  = 2'd0;
        end else if (WIDE_VARIANT || div_reg == 2'd3) begin
            ramp_next = (ramp_reg + 14'd1) & WMASK;
        end
        norm_data = conv_data_in & WMASK;
        if (cfg_reg.twos_complement) begin
            norm_data = norm_data ^ (WMASK & ~(WMASK >> 1));
        end
        case (pat_sel)
            `ACR_PAT_NORMAL: data_next = norm_data;
            `ACR_PAT_ZEROS:  data_next = 14'h0000;
            `ACR_PAT_ONES:   data_next = WMASK;
            `ACR_PAT_TOGGLE: data_next = WMASK &
                (tog_reg ? `ACR_TOGGLE_B : `ACR_TOGGLE_A);
            `ACR_PAT_RAMP:   data_next = ramp_reg;
            `ACR_PAT_USER:   data_next = WIDE_VARIANT ? user_pat
                : {2'b00, user_pat[13:2]};
            default:         data_next = 14'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_reg  <= 1'b0;
            cfg_reg  <= '0;
            data_reg <= 14'h0000;
            ramp_reg <= 14'h0000;
            tog_reg  <= 1'b0;
            div_reg  <= 2'd0;
        end else begin
            pin_reg  <= pin_next;
            cfg_reg  <= cfg_next;
            data_reg <= data_next;
            ramp_reg <= ramp_next;
            tog_reg  <= tog_next;
            div_reg  <= div_next;
        end
    end

    assign overrange_serial_out_pin_out = pin_reg;
    assign sample_data_out = data_reg;
    assign cfg_out = cfg_reg;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    soft_reset_clear_a: assert property (
        wr_commit && wr_addr == `ACR_ADDR_GLOBAL && wr_data[1]
        |=> regs_reg[3] == `ACR_RST_GAIN_PAT && regs_reg[0] == 8'h00)
        else $error("soft reset did not restore defaults");

    pin_mux_a: assert property (
        !readback_on |=> overrange_serial_out_pin_out
            == $past(overrange_flag_in))
        else $error("shared pin not showing over-range");

    swing_gate_a: assert property (
        regs_reg[9][1:0] != 2'h3 |=> cfg_out.swing_code == 6'h00)
        else $error("swing applied without override");

    readback_lock_a: assert property (
        readback_on && wr_commit && wr_addr != 8'h00
        |=> $stable(regs_reg[1]) && $stable(regs_reg[3]))
        else $error("write accepted during readback");

    zero_pattern_a: assert property (
        pat_sel == 3'h1 |=> sample_data_out == 14'h0000)
        else $error("zero pattern wrong");

    toggle_alt_a: assert property (
        pat_sel == 3'h3 ##1 pat_sel == 3'h3
        |=> sample_data_out == (WMASK & ~$past(sample_data_out)))
        else $error("toggle pattern did not alternate");

    ramp_step_a: assert property (
        WIDE_VARIANT && pat_sel == 3'h4 [*3]
        |=> sample_data_out == (($past(sample_data_out) + 14'd1) & WMASK))
        else $error("ramp did not step by one");

    user_pattern_a: assert property (
        WIDE_VARIANT && pat_sel == 3'h5 |=> sample_data_out == $past(user_pat))
        else $error("user pattern not passed");

    format_force_a: assert property (
        fmt_code == 2'h2 |=> cfg_out.twos_complement)
        else $error("twos complement not forced");

    iface_force_a: assert property (
        if_code == 2'h3 |=> !cfg_out.lvds_select)
        else $error("parallel interface not forced");

    frame_commit_a: assert property (
        wr_commit |=> sp_state_reg == ACR_SP_IDLE)
        else $error("frame not closed after commit");

endmodule : acr_bank

// ---- tb/acr_ser_ctrl.sv ----
// serial controller model that programs and reads back the bank
`timescale 1ns/1ps

module acr_ser_ctrl (
    // pacing clock
    input  wire logic sys_clk_in,
    // serial pins toward the bank
    output logic      ser_enable_n_out,
    output logic      ser_clock_out,
    output logic      ser_data_out,
    input  wire logic sdout_in
);
    initial begin
        ser_enable_n_out = 1'b1;
        ser_clock_out    = 1'b0;
        ser_data_out     = 1'b0;
    end

    // five sys clocks high and six low a phase, above the synchroniser's minimum of three
    task automatic frame(input logic [7:0] addr, input logic [7:0] data,
                         input int nbits, output logic [7:0] rd);
        logic [15:0] word;
        word = {addr, data};
        rd   = 8'h00;
        @(posedge sys_clk_in) ser_enable_n_out <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            @(posedge sys_clk_in) ser_data_out <= word[15 - i];
            repeat (4) @(posedge sys_clk_in);
            // read bit has settled in the low phase, taken before the rise
            @(negedge sys_clk_in) rd = {rd[6:0], sdout_in};
            @(posedge sys_clk_in) ser_clock_out <= 1'b1;
            repeat (4) @(posedge sys_clk_in);
            @(posedge sys_clk_in) ser_clock_out <= 1'b0;
        end
        repeat (2) @(posedge sys_clk_in);
        @(posedge sys_clk_in) begin
            ser_enable_n_out <= 1'b1;
            // a released data line does not keep its last level
            ser_data_out     <= ~ser_data_out;
        end
        repeat (8) @(posedge sys_clk_in);
    endtask : frame
endmodule : acr_ser_ctrl

// ---- tb/testbench.sv ----
// self-checking bench for the converter configuration bank
`timescale 1ns/1ps

module testbench;
    import acr_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rst;
        logic [7:0] rexp;
    } acr_row_s;

    logic        sys_clk_in = 1'b0;
    logic        rst_n_in   = 1'b0;
    logic        ovr_in     = 1'b0;
    logic [13:0] conv_in    = 14'h1234;
    logic        fmt_pin    = 1'b0;
    logic        sen_n;
    logic        sclk;
    logic        sdat;
    logic        pin_w;
    logic [13:0] data_w;
    logic [13:0] data_n;
    acr_cfg_s    cfg_w;
    logic [7:0]  rd;
    logic [13:0] v;
    logic [13:0] vn;
    int          n_fail       = 0;
    int          total_checks = 0;

    acr_row_s rows [11] = '{
        '{8'h01, 8'hf8, 8'h00, 8'hf8},
        '{8'h43, 8'h03, 8'h00, 8'h03},
        '{8'h03, 8'h03, 8'h00, 8'h03},
        '{8'h4a, 8'h01, 8'h00, 8'h01},
        '{8'h25, 8'hc5, 8'h50, 8'hc5},
        '{8'h26, 8'h03, 8'h00, 8'h03},
        '{8'h3d, 8'ha0, 8'h00, 8'ha0},
        '{8'h3f, 8'h2a, 8'h00, 8'h2a},
        '{8'h40, 8'h5b, 8'h00, 8'h5b},
        '{8'h41, 8'hf8, 8'h00, 8'hf8},
        '{8'h02, 8'h55, 8'h00, 8'h00}
    };
    logic [2:0]  pat_code [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
    logic [13:0] pat_wide [4] = '{14'h3234, 14'h0, 14'h3fff, 14'h2a5b};
    logic [13:0] pat_nar  [4] = '{14'h0a34, 14'h0, 14'h0fff, 14'h0a96};
    localparam logic [24:0] CFG_EXP =
        {6'h3e, 4'hf, 1'b1, 8'hc7, 3'b110, 2'h3, 1'b1};
    localparam logic [24:0] CFG_RST = {11'h0, 4'h5, 10'h0};

    initial begin
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    acr_bank #(.WIDE_VARIANT(1'b1)) uut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .ser_enable_n_in(sen_n), .ser_clock_in(sclk), .ser_data_in(sdat),
        .overrange_flag_in(ovr_in), .conv_data_in(conv_in),
        .format_select_pin_in(fmt_pin),
        .overrange_serial_out_pin_out(pin_w),
        .sample_data_out(data_w), .cfg_out(cfg_w));

    acr_bank #(.WIDE_VARIANT(1'b0)) uut_narrow (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .ser_enable_n_in(sen_n), .ser_clock_in(sclk), .ser_data_in(sdat),
        .overrange_flag_in(ovr_in), .conv_data_in(conv_in),
        .format_select_pin_in(fmt_pin),
        .overrange_serial_out_pin_out(), .sample_data_out(data_n),
        .cfg_out());

    acr_ser_ctrl ctrl (
        .sys_clk_in(sys_clk_in), .ser_enable_n_out(sen_n),
        .ser_clock_out(sclk), .ser_data_out(sdat), .sdout_in(pin_w));

    function automatic bit ne(input logic [24:0] exp, input logic [24:0] got);
        total_checks++;
        if (got !== exp) n_fail++;
        return got !== exp;
    endfunction : ne

    task automatic miss(input string nm, input logic [24:0] exp, got);
        $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    endtask : miss

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ctrl.frame(a, d, 16, rd);
    endtask : wr

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (100000) @(posedge sys_clk_in);
        n_fail++;
        $display("unexpected run length: expected end, seen hang");
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        // defaults seen through readback, where this write must be dropped
        wr(8'h00, 8'h01);
        wr(8'h26, 8'h03);
        foreach (rows[k]) begin
            ctrl.frame(rows[k].addr, 8'h00, 16, rd);
            if (ne(rows[k].rst, rd))
                miss("default", rows[k].rst, rd);
        end
        wr(8'h00, 8'h00);
        $display("done: defaults");
        foreach (rows[k]) wr(rows[k].addr, rows[k].wdata);
        ctrl.frame(8'h26, 8'h00, 12, rd);
        wr(8'h00, 8'h01);
        foreach (rows[k]) begin
            ctrl.frame(rows[k].addr, 8'h00, 16, rd);
            if (ne(rows[k].rexp, rd))
                miss("readback", rows[k].rexp, rd);
        end
        wr(8'h00, 8'h00);
        if (ne(CFG_EXP, cfg_w)) miss("config", CFG_EXP, cfg_w);
        wr(8'h43, 8'h00);
        if (ne(6'h00, cfg_w.swing_code))
            miss("swing", 6'h00, cfg_w.swing_code);
        $display("done: register table");
        for (int k = 0; k < 4; k++) begin
            wr(8'h25, {5'h0a, pat_code[k]});
            @(negedge sys_clk_in);
            if (ne(pat_wide[k], data_w))
                miss("wide", pat_wide[k], data_w);
            if (ne(pat_nar[k], data_n))
                miss("narrow", pat_nar[k], data_n);
        end
        wr(8'h25, 8'h53);
        @(negedge sys_clk_in);
        v  = data_w;
        vn = data_n;
        if (ne(1'b1, v === 14'h1555 || v === 14'h2aaa))
            miss("toggle", 14'h1555, v);
        if (ne(1'b1, vn === 14'h0555 || vn === 14'h0aaa))
            miss("toggle", 14'h0555, vn);
        repeat (4) begin
            @(negedge sys_clk_in);
            if (ne(v ^ 14'h3fff, data_w))
                miss("toggle", v ^ 14'h3fff, data_w);
            if (ne(vn ^ 14'h0fff, data_n))
                miss("toggle", vn ^ 14'h0fff, data_n);
            v  = data_w;
            vn = data_n;
        end
        wr(8'h25, 8'h54);
        @(negedge sys_clk_in);
        v  = data_w;
        vn = data_n;
        repeat (8) @(negedge sys_clk_in);
        if (ne(v + 14'd8, data_w)) miss("ramp", v + 14'd8, data_w);
        if (ne(vn + 14'd2, data_n))
            miss("ramp", vn + 14'd2, data_n);
        $display("done: patterns");
        // pin level chosen so that a forced code and the pin disagree
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk_in) fmt_pin <= (k == 1 || k == 2) ? 1'b0 : 1'b1;
            wr(8'h41, {2'(k), 6'h00});
            wr(8'h3d, {(k == 1) ? 2'b00 : 2'(k), 6'h20});
            if (ne(k < 2, cfg_w.lvds_select))
                miss("iface", k < 2, cfg_w.lvds_select);
            if (ne(k % 2 == 0, cfg_w.twos_complement))
                miss("fmt", k % 2 == 0, cfg_w.twos_complement);
        end
        $display("done: format select");
        @(posedge sys_clk_in) fmt_pin <= 1'b0;
        wr(8'h00, 8'h01);
        wr(8'h00, 8'h02);
        if (ne(CFG_RST, cfg_w)) miss("soft reset", CFG_RST, cfg_w);
        @(posedge sys_clk_in) ovr_in <= 1'b1;
        repeat (2) @(negedge sys_clk_in);
        if (ne(1'b1, pin_w)) miss("overrange", 1, pin_w);
        @(posedge sys_clk_in) ovr_in <= 1'b0;
        repeat (2) @(negedge sys_clk_in);
        if (ne(1'b0, pin_w)) miss("overrange", 0, pin_w);
        wr(8'h00, 8'h01);
        ctrl.frame(8'h25, 8'h00, 16, rd);
        if (ne(8'h50, rd)) miss("gain default", 8'h50, rd);
        wr(8'h00, 8'h00);
        $display("done: soft reset");
        end_of_test();
    end
endmodule : testbench
